// File: common/bsc_cfg.svh
// Constants for the blit setup controller: register map, fields, device offsets.
// Assumes a drawing engine reached through a four-phase register write port.
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH
`define BSC_IX_CTRL 4'h0
`define BSC_IX_STAT 4'h1
`define BSC_IX_SSTART 4'h2
`define BSC_IX_SEND 4'h3
`define BSC_IX_YSTEP 4'h4
`define BSC_IX_DX 4'h5
`define BSC_IX_YL 4'h6
`define BSC_IX_YTERM 4'h7
`define BSC_IX_PAT 4'h8
`define BSC_IX_POFF 4'h9
`define BSC_IX_SCAN 4'hA
`define BSC_IX_FOREGROUND_COLOUR 4'hB
`define BSC_IX_BACKGROUND_COLOUR 4'hC
`define BSC_C_GO 0
`define BSC_C_MODE 2:1
`define BSC_C_PW 5:4
`define BSC_C_MC 7:6
`define BSC_C_ATYPE 10:8
`define BSC_C_BOP 15:12
`define BSC_C_TRANSC 16
`define BSC_C_SGNZ 17
`define BSC_LO 15:0
`define BSC_HI 31:16
`define BSC_POFF_X 2:0
`define BSC_POFF_Y 10:8
`define BSC_S_DONE 1
`define BSC_OKAY 2'h0
`define BSC_SLVERR 2'h2
`define BSC_DEV_SEND 14'h1C00
`define BSC_DEV_SSTART 14'h1C04
`define BSC_DEV_YSTEP 14'h1C08
`define BSC_DEV_LEFT 14'h1C0C
`define BSC_DEV_RIGHT 14'h1C10
`define BSC_DEV_DEST_Y_START 14'h1C14
`define BSC_DEV_LEN 14'h1C18
`define BSC_DEV_SCAN 14'h1C1C
`define BSC_DEV_FOREGROUND_COLOUR 14'h1C20
`define BSC_DEV_BACKGROUND_COLOUR 14'h1C24
`define BSC_DEV_GO 14'h1D28
`define BSC_TRIG_HI 6'h1D
`define BSC_LAST_IDX 4'hA
`define BSC_PW8 2'h0
`define BSC_WIDTH_16BPP 2'h1
`define BSC_WIDTH_24BPP 2'h2
`define BSC_WIDTH_32BPP 2'h3
`define BSC_MC00 2'h0
`define BSC_RPL 3'h0
`define BSC_RASTER_ACCESS 3'h1
`define BSC_BLT_XY 4'h2
`define BSC_BLT_LIN 4'h7
`define BSC_OPCOD 4'h8
`define BSC_FAST_CODE 32'h040A600C
`define BSC_PAT_STEP 18'h00020
`define BSC_PEND8 3'h2
`define BSC_PEND16 3'h4
`define BSC_PEND32 3'h6
`define BSC_PEND24 18'h00007
`define BSC_M16 18'h0000F
`define BSC_M32 18'h0001F
`define BSC_M64 18'h0003F
`define BSC_M128 18'h0007F
`define BSC_CHIP 17:16
`define BSC_SLOT1 8'h08
`define BSC_SLOT2 8'h10
`define BSC_SLOT3 8'h18
`endif

// File: common/bsc_pkg.sv
// Types shared by the blit setup controller.
// Assumes nothing of its surroundings.
`default_nettype none
package bsc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_WRITE, ST_WAIT} bsc_state_e;
	typedef enum logic [1:0] {MD_XY, MD_LIN, MD_PAT, MD_FAST} bsc_mode_e;
	typedef logic [17:0] bsc_addr_t;
endpackage
`default_nettype wire

// File: hdl/bsc_ctrl.sv
// Blit setup controller: AXI4-Lite order registers, setup checks, device loader.
// Assumes a device write port with a four-phase ack pin and a busy pin.
`timescale 1ns/1ns
`default_nettype none
`include "bsc_cfg.svh"
module bsc_ctrl
	import bsc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [5:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [5:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Drawing engine register port
	output logic dev_wr_valid,
	output logic [13:0] dev_wr_addr,
	output logic [31:0] dev_wr_data,
	input wire logic dev_wr_ack,
	input wire logic dev_busy
);
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic aw_got_q, w_got_q;
	logic [5:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [31:0] cfg_q [0:12];
	logic done_q;
	logic [7:0] err_q;
	bsc_state_e st_q;
	logic [3:0] idx_q;
	logic sent_q;
	logic dev_wr_valid_q;
	logic [13:0] dev_wr_addr_q;
	logic [31:0] dev_wr_data_q;
	logic ack_m_q, ack_s_q, busy_m_q, busy_s_q;

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;
	assign dev_wr_valid = dev_wr_valid_q;
	assign dev_wr_addr = dev_wr_addr_q;
	assign dev_wr_data = dev_wr_data_q;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
		begin
			if (s[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		end
		return r;
	endfunction

	// Write address and data may arrive in either order
	wire aw_take = awvalid && awready_q;
	wire w_take = wvalid && wready_q;
	wire wr_do = aw_got_q && w_got_q && !bvalid_q;
	wire [3:0] wix = aw_addr_q[5:2];
	wire wr_map = wix <= `BSC_IX_BACKGROUND_COLOUR;
	wire go = wr_do && wix == `BSC_IX_CTRL && w_strb_q[0] && w_data_q[`BSC_C_GO];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_addr_q <= 6'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end
		else
		begin
			aw_got_q <= (aw_got_q || aw_take) && !wr_do;
			awready_q <= !((aw_got_q || aw_take) && !wr_do);
			w_got_q <= (w_got_q || w_take) && !wr_do;
			wready_q <= !((w_got_q || w_take) && !wr_do);
			if (aw_take)
				aw_addr_q <= awaddr;
			if (w_take)
			begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= `BSC_OKAY;
		end
		else if (wr_do)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_map ? `BSC_OKAY : `BSC_SLVERR;
		end
		else if (bready)
			bvalid_q <= 1'b0;
	end

	// Setup is frozen outside idle so the engine sees one consistent blit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 13; i++)
				cfg_q[i] <= 32'h00000000;
		end
		else if (wr_do && wr_map && wix != `BSC_IX_STAT && st_q == ST_IDLE)
			cfg_q[wix] <= merge(cfg_q[wix], w_data_q, w_strb_q)
				& ~(wix == `BSC_IX_CTRL ? 32'h00000001 : 32'h00000000);
	end

	wire [31:0] ctrl = cfg_q[`BSC_IX_CTRL];
	wire bsc_mode_e mode = bsc_mode_e'(ctrl[`BSC_C_MODE]);
	wire [1:0] pw = ctrl[`BSC_C_PW];
	wire [1:0] mc = ctrl[`BSC_C_MC];
	wire [2:0] atype = ctrl[`BSC_C_ATYPE];
	wire [3:0] bop = ctrl[`BSC_C_BOP];
	wire transc = ctrl[`BSC_C_TRANSC];
	wire pat = mode == MD_PAT;
	wire fast = mode == MD_FAST;
	wire bsc_addr_t pat_base = cfg_q[`BSC_IX_PAT][17:0];
	wire [2:0] pox = cfg_q[`BSC_IX_POFF][`BSC_POFF_X];
	wire [2:0] poy = cfg_q[`BSC_IX_POFF][`BSC_POFF_Y];
	// Source addresses are 18 bits; pattern start is derived here
	wire bsc_addr_t s_start = pat ? pat_base + {15'h0000, pox} + {10'h000, poy, 5'h00}
		: cfg_q[`BSC_IX_SSTART][17:0];
	logic [2:0] pend;
	always_comb
	begin
		case (pw)
			`BSC_PW8: pend = `BSC_PEND8;
			`BSC_WIDTH_16BPP: pend = `BSC_PEND16;
			default: pend = `BSC_PEND32;
		endcase
	end
	wire bsc_addr_t s_end = !pat ? cfg_q[`BSC_IX_SEND][17:0]
		: (pw == `BSC_WIDTH_24BPP ? s_start + `BSC_PEND24 : {s_start[17:3], s_start[2:0] + pend});
	wire bsc_addr_t s_step = pat ? `BSC_PAT_STEP : cfg_q[`BSC_IX_YSTEP][17:0];
	wire [15:0] left = cfg_q[`BSC_IX_DX][`BSC_LO];
	wire [15:0] right = cfg_q[`BSC_IX_DX][`BSC_HI];
	wire [15:0] lines = cfg_q[`BSC_IX_YL][`BSC_HI];
	wire [15:0] width = right - left + 16'h0001;
	wire [31:0] dst_px = width * lines;
	wire bsc_addr_t s_span = s_end - s_start;
	wire ytm = (pw == `BSC_PW8 || pw == `BSC_WIDTH_24BPP) || (mc != `BSC_MC00 && pw == `BSC_WIDTH_16BPP);
	wire bsc_addr_t dterm = {2'h0, left} + (ytm ? cfg_q[`BSC_IX_YTERM][17:0] : 18'h00000);
	logic [17:0] amask;
	always_comb
	begin
		case (pw)
			`BSC_WIDTH_16BPP: amask = mc == `BSC_MC00 ? `BSC_M32 : `BSC_M64;
			`BSC_WIDTH_32BPP: amask = mc == `BSC_MC00 ? `BSC_M16 : `BSC_M32;
			default: amask = mc == `BSC_MC00 ? `BSC_M64 : `BSC_M128;
		endcase
	end
	wire [7:0] plow = pat_base[7:0];
	wire [7:0] err_vec;
	assign err_vec[0] = !fast && atype != `BSC_RPL && atype != `BSC_RASTER_ACCESS;
	assign err_vec[1] = !fast && atype == `BSC_RPL && bop != 4'h0 && bop != 4'h3
		&& bop != 4'hC && bop != 4'hF;
	assign err_vec[2] = !fast && transc && pw == `BSC_WIDTH_24BPP;
	assign err_vec[3] = mode == MD_LIN ? {13'h0000, s_span} + 32'h00000001 != dst_px
		: (!pat && s_span != {2'h0, right - left});
	assign err_vec[4] = fast && (s_start & amask) != (dterm & amask);
	assign err_vec[5] = fast && s_start[`BSC_CHIP] != dterm[`BSC_CHIP];
	assign err_vec[6] = fast && mc[1];
	assign err_vec[7] = pat && (pw == `BSC_WIDTH_24BPP ? (plow != 8'h00 && plow != `BSC_SLOT2)
		: (plow != 8'h00 && plow != `BSC_SLOT1 && plow != `BSC_SLOT2
		&& !(plow == `BSC_SLOT3 && pw == `BSC_PW8)));

	// Direction defaults for linear and pattern sources
	wire sgnz = mode == MD_XY ? ctrl[`BSC_C_SGNZ] : 1'b1;
	wire [31:0] dwg = fast ? `BSC_FAST_CODE : {1'b0, transc, pat,
		mode == MD_LIN ? `BSC_BLT_LIN : `BSC_BLT_XY, 1'b0, 4'h0, bop, 1'b0, 1'b1, sgnz,
		5'h00, mode == MD_LIN, atype, `BSC_OPCOD};

	logic [13:0] dev_addr_d;
	logic [31:0] dev_data_d;
	always_comb
	begin
		dev_addr_d = `BSC_DEV_GO;
		dev_data_d = dwg;
		case (idx_q)
			4'h0: {dev_addr_d, dev_data_d} = {`BSC_DEV_SEND, 14'h0000, s_end};
			4'h1: {dev_addr_d, dev_data_d} = {`BSC_DEV_SSTART, 14'h0000, s_start};
			4'h2: {dev_addr_d, dev_data_d} = {`BSC_DEV_YSTEP, 14'h0000, s_step};
			4'h3: {dev_addr_d, dev_data_d} = {`BSC_DEV_LEFT, 16'h0000, left};
			4'h4: {dev_addr_d, dev_data_d} = {`BSC_DEV_RIGHT, 16'h0000, right};
			4'h5: {dev_addr_d, dev_data_d} = {`BSC_DEV_DEST_Y_START, 16'h0000,
				cfg_q[`BSC_IX_YL][`BSC_LO]};
			4'h6: {dev_addr_d, dev_data_d} = {`BSC_DEV_LEN, 16'h0000, lines};
			4'h7: {dev_addr_d, dev_data_d} = {`BSC_DEV_SCAN, cfg_q[`BSC_IX_SCAN]};
			4'h8: {dev_addr_d, dev_data_d} = {`BSC_DEV_FOREGROUND_COLOUR, cfg_q[`BSC_IX_FOREGROUND_COLOUR]};
			4'h9: {dev_addr_d, dev_data_d} = {`BSC_DEV_BACKGROUND_COLOUR, cfg_q[`BSC_IX_BACKGROUND_COLOUR]};
			default: {dev_addr_d, dev_data_d} = {`BSC_DEV_GO, dwg};
		endcase
	end

	// Pins are asynchronous to aclk
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			{ack_m_q, ack_s_q, busy_m_q, busy_s_q} <= 4'h0;
		else
		begin
			ack_m_q <= dev_wr_ack;
			ack_s_q <= ack_m_q;
			busy_m_q <= dev_busy;
			busy_s_q <= busy_m_q;
		end
	end

	// Four-phase writes; the trigger alias goes last and nothing follows until idle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q <= ST_IDLE;
			idx_q <= 4'h0;
			sent_q <= 1'b0;
			err_q <= 8'h00;
			dev_wr_valid_q <= 1'b0;
			dev_wr_addr_q <= 14'h0000;
			dev_wr_data_q <= 32'h00000000;
		end
		else
		begin
			case (st_q)
				ST_IDLE:
					if (go)
						st_q <= ST_CHECK;
				ST_CHECK:
				begin
					err_q <= err_vec;
					idx_q <= 4'h0;
					st_q <= err_vec != 8'h00 ? ST_IDLE : ST_WRITE;
				end
				ST_WRITE:
					if (!dev_wr_valid_q && !sent_q && !ack_s_q)
					begin
						dev_wr_valid_q <= 1'b1;
						dev_wr_addr_q <= dev_addr_d;
						dev_wr_data_q <= dev_data_d;
					end
					else if (dev_wr_valid_q && ack_s_q)
					begin
						dev_wr_valid_q <= 1'b0;
						sent_q <= 1'b1;
					end
					else if (sent_q && !ack_s_q)
					begin
						sent_q <= 1'b0;
						if (idx_q == `BSC_LAST_IDX)
							st_q <= ST_WAIT;
						else
							idx_q <= idx_q + 4'h1;
					end
				ST_WAIT:
					if (!busy_s_q)
						st_q <= ST_IDLE;
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end

	// Set wins over a software clear in the same cycle
	wire done_set = st_q == ST_WAIT && !busy_s_q;
	wire done_clr = wr_do && wix == `BSC_IX_STAT && w_strb_q[0] && w_data_q[`BSC_S_DONE];
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			done_q <= 1'b0;
		else if (done_set)
			done_q <= 1'b1;
		else if (done_clr || go)
			done_q <= 1'b0;
	end

	wire [3:0] rix = araddr[5:2];
	wire [31:0] status = {22'h000000, err_q, done_q, st_q != ST_IDLE};
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `BSC_OKAY;
		end
		else if (arvalid && arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= rix <= `BSC_IX_BACKGROUND_COLOUR ? `BSC_OKAY : `BSC_SLVERR;
			rdata_q <= rix == `BSC_IX_STAT ? status
				: (rix <= `BSC_IX_BACKGROUND_COLOUR ? cfg_q[rix] : 32'h00000000);
		end
		else if (rvalid_q && rready)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire last_w = dev_wr_valid_q && idx_q == `BSC_LAST_IDX;
	sequence s_check_bad;
		st_q == ST_CHECK && err_vec != 8'h00;
	endsequence
	sequence s_acked;
		dev_wr_valid_q && ack_s_q;
	endsequence

	a_trigger_last: assert property (dev_wr_valid_q && dev_wr_addr_q[13:8] == `BSC_TRIG_HI
		|-> idx_q == `BSC_LAST_IDX) else $error("trigger write not last");
	a_pattern_end: assert property (dev_wr_valid_q && idx_q == 4'h0 && pat
		&& pw != `BSC_WIDTH_24BPP |-> dev_wr_data_q[17:3] == s_start[17:3])
		else $error("pattern end bad");
	a_pattern_step: assert property (dev_wr_valid_q && idx_q == 4'h2 && pat
		|-> dev_wr_data_q == {14'h0000, `BSC_PAT_STEP}) else $error("pattern step not 32");
	a_fast_code: assert property (last_w && fast |-> dev_wr_data_q == `BSC_FAST_CODE)
		else $error("fast code wrong");
	a_rpl_bop: assert property (last_w && !fast && dev_wr_data_q[6:4] == `BSC_RPL
		|-> dev_wr_data_q[19:16] inside {4'h0, 4'h3, 4'hC, 4'hF})
		else $error("replace with bad op");
	a_transc_24: assert property (last_w && !fast && pw == `BSC_WIDTH_24BPP
		|-> !dev_wr_data_q[30]) else $error("transparency at 24 bpp");
	a_refuse_bad: assert property (s_check_bad |=>
		(st_q == ST_IDLE && !dev_wr_valid_q) [*2]) else $error("bad setup not refused");
	a_dev_drop: assert property (s_acked |=> !dev_wr_valid_q ##1 !dev_wr_valid_q)
		else $error("device write not released");
	a_dev_hold: assert property (dev_wr_valid_q && !ack_s_q |=> dev_wr_valid_q
		&& $stable(dev_wr_data_q) && $stable(dev_wr_addr_q)) else $error("device write moved");
	a_wait_quiet: assert property (st_q == ST_WAIT
		|-> !dev_wr_valid_q && $stable(cfg_q[`BSC_IX_SSTART])) else $error("write during blit");
	a_bresp_hold: assert property (bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
		else $error("write response dropped");
endmodule
`default_nettype wire

// File: verification/bsc_dev_model.sv
// Drawing engine stand-in: four-phase register port, trigger window and busy flag.
// Assumes the controller holds valid, address and data until it sees ack high.
`timescale 1ns/1ns
`default_nettype none
module bsc_dev_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic wr_valid,
	input wire logic [13:0] wr_addr,
	input wire logic [31:0] wr_data,
	output logic wr_ack,
	output logic busy,
	// Pacing
	input wire logic slow
);
	logic [31:0] regs [0:15];
	logic [13:0] last_a;
	int nwr, ntrig, viol, dly, run;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ack <= 1'b0;
			busy <= 1'b0;
			{nwr, ntrig, viol, dly, run} <= '0;
		end
		else
		begin
			if (run > 0)
				run <= run - 1;
			else
				busy <= 1'b0;
			if (!wr_valid)
			begin
				wr_ack <= 1'b0;
				dly <= 0;
			end
			else if (!wr_ack && dly < (slow ? 5 : 0))
				dly <= dly + 1;
			else if (!wr_ack)
			begin
				// Plain storage; key, mask and direction are consumed as held
				wr_ack <= 1'b1;
				regs[wr_addr[5:2]] <= wr_data;
				last_a <= wr_addr;
				nwr <= nwr + 1;
				// Setup must not move under a running blit
				if (busy)
					viol <= viol + 1;
				// Busy rises with ack, so it is up before ack falls
				if (wr_addr[13:8] == 6'h1D)
				begin
					busy <= 1'b1;
					run <= slow ? 40 : 6;
					ntrig <= ntrig + 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the blit setup controller over AXI4-Lite.
// Assumes the engine stand-in bsc_dev_model answers the device register port.
`timescale 1ns/1ns
`default_nettype none
`include "bsc_cfg.svh"
module tb_top;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
	logic awready, wready, bvalid, arready, rvalid, dev_wr_valid, dev_wr_ack, dev_busy;
	logic [5:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [31:0] wdata, rdata, rd_v, dev_wr_data;
	logic [1:0] bresp, rresp, br, rr;
	logic [13:0] dev_wr_addr;
	int errors, samples_checked;

	bsc_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.dev_wr_valid(dev_wr_valid), .dev_wr_addr(dev_wr_addr), .dev_wr_data(dev_wr_data),
		.dev_wr_ack(dev_wr_ack), .dev_busy(dev_busy));
	bsc_dev_model dev (.clk(aclk), .rst_n(aresetn), .wr_valid(dev_wr_valid),
		.wr_addr(dev_wr_addr), .wr_data(dev_wr_data), .wr_ack(dev_wr_ack),
		.busy(dev_busy), .slow(slow));

	initial aclk = 1'b0;
	always #25 aclk = ~aclk;

	task automatic tally_and_finish();
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Address and data are offered together; each is dropped once taken
	task automatic wr(input logic [3:0] ix, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= {ix, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		br = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] ix);
		@(posedge aclk);
		araddr <= {ix, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rd_v = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask

	function automatic logic [31:0] ctl(input logic [1:0] md, input logic [1:0] pw,
		input logic [1:0] mc, input logic [2:0] at, input logic [3:0] bop, input logic tr);
		return {15'h0, tr, bop, 1'b0, at, mc, pw, 1'b0, md, 1'b0};
	endfunction

	task automatic setup(input logic [31:0] s, input logic [31:0] e, input logic [15:0] l,
		input logic [15:0] r);
		wr(`BSC_IX_SSTART, s);
		wr(`BSC_IX_SEND, e);
		wr(`BSC_IX_DX, {r, l});
	endtask

	// A refused order must leave the engine untouched and never sets done,
	// so the poll ends on busy low rather than on done
	task automatic blit(input logic [31:0] c, input logic [31:0] st, input bit mid = 1'b0);
		int n0;
		int t0;
		int i;
		n0 = dev.nwr;
		t0 = dev.ntrig;
		wr(`BSC_IX_CTRL, c | 32'h1);
		if (mid)
			wr(`BSC_IX_SSTART, 32'h0);
		i = 0;
		do
		begin
			rd(`BSC_IX_STAT);
			i++;
		end
		while (rd_v[0] !== 1'b0 && i < 300);
		chk(rd_v, st);
		chk(32'(dev.nwr - n0), (st[9:2] == 8'h0) ? 32'd11 : 32'd0);
		chk(32'(dev.ntrig - t0), (st[9:2] == 8'h0) ? 32'd1 : 32'd0);
		if (st[9:2] == 8'h0)
			chk({18'h0, dev.last_a}, {18'h0, `BSC_DEV_GO});
		wr(`BSC_IX_STAT, 32'h2);
	endtask

	task automatic t_reset();
		rd(`BSC_IX_STAT);
		chk(rd_v, 32'h0);
		rd(4'hD);
		chk(rd_v, 32'h0);
		chk({30'h0, rr}, {30'h0, `BSC_SLVERR});
		wr(4'hD, 32'h1);
		chk({30'h0, br}, {30'h0, `BSC_SLVERR});
		wr(`BSC_IX_FOREGROUND_COLOUR, 32'h11223344);
		wstrb <= 4'h2;
		wr(`BSC_IX_FOREGROUND_COLOUR, 32'hAABBCCDD);
		wstrb <= 4'hF;
		rd(`BSC_IX_FOREGROUND_COLOUR);
		chk(rd_v, 32'h1122CC44);
	endtask

	task automatic t_xy();
		logic [31:0] ex [0:9];
		ex = '{32'h3FF0F, 32'h3FF00, 32'h100, 32'h10, 32'h1F, 32'h5, 32'h3, 32'h5,
			32'hA5A5A5A5, 32'h00FF00FF};
		slow <= 1'b1;
		setup(32'h3FF00, 32'h3FF0F, 16'h10, 16'h1F);
		wr(`BSC_IX_YSTEP, 32'h100);
		wr(`BSC_IX_YL, 32'h0003_0005);
		wr(`BSC_IX_SCAN, 32'h5);
		wr(`BSC_IX_FOREGROUND_COLOUR, 32'hA5A5A5A5);
		wr(`BSC_IX_BACKGROUND_COLOUR, 32'h00FF00FF);
		blit(ctl(0, 3, 0, `BSC_RASTER_ACCESS, 4'h6, 1'b1), 32'h2, 1'b1);
		for (int i = 0; i < 10; i++)
			chk(dev.regs[i], ex[i]);
		chk(dev.regs[10], 32'h44064018);
		rd(`BSC_IX_SSTART);
		chk(rd_v, 32'h3FF00);
		chk(32'(dev.viol), 32'h0);
		rd(`BSC_IX_STAT);
		chk(rd_v, 32'h0);
		slow <= 1'b0;
	endtask

	task automatic t_ops();
		for (int b = 0; b < 16; b++)
			blit(ctl(0, 0, 0, `BSC_RPL, 4'(b), 0), (b % 3 == 0 && b != 6 && b != 9) ?
				32'h2 : 32'h8);
		blit(ctl(0, 0, 0, 3'h2, 4'h6, 0), 32'h4);
		blit(ctl(0, 2, 0, `BSC_RASTER_ACCESS, 4'h6, 1'b1), 32'h10);
		wr(`BSC_IX_SEND, 32'h3FF10);
		blit(ctl(0, 0, 0, `BSC_RASTER_ACCESS, 4'h6, 0), 32'h20);
	endtask

	task automatic t_lin();
		setup(32'h0, 32'h2F, 16'h0, 16'hF);
		wr(`BSC_IX_YL, 32'h0003_0007);
		blit(ctl(1, 0, 0, `BSC_RASTER_ACCESS, 4'h6, 0), 32'h2);
		chk(dev.regs[0], 32'h2F);
		chk(dev.regs[5], 32'h7);
		chk(dev.regs[6], 32'h3);
		chk(dev.regs[10], 32'h0E066098);
	endtask

	task automatic t_fast();
		setup(32'h20, 32'h2F, 16'h40, 16'h4F);
		blit(ctl(3, 1, 0, `BSC_RPL, 4'hC, 0), 32'h2);
		chk(dev.regs[10], `BSC_FAST_CODE);
		setup(32'h20, 32'h2F, 16'h41, 16'h50);
		blit(ctl(3, 1, 0, `BSC_RPL, 4'hC, 0), 32'h40);
		wr(`BSC_IX_YTERM, 32'h40);
		setup(32'h80, 32'h8F, 16'h0, 16'hF);
		blit(ctl(3, 0, 0, `BSC_RPL, 4'hC, 0), 32'h2);
		// Aligned under both layouts, so only the layout itself is refused
		blit(ctl(3, 1, 2'h2, `BSC_RPL, 4'hC, 0), 32'h100);
		blit(ctl(3, 0, 1, `BSC_RPL, 4'hC, 0), 32'h40);
		setup(32'h10080, 32'h1008F, 16'h0, 16'hF);
		blit(ctl(3, 0, 0, `BSC_RPL, 4'hC, 0), 32'h80);
	endtask

	task automatic pat(input logic [1:0] pw, input logic [31:0] b, input logic [31:0] s,
		input logic [31:0] e, input logic [31:0] st);
		wr(`BSC_IX_PAT, b);
		blit(ctl(2, pw, 0, `BSC_RASTER_ACCESS, 4'h6, 0), st);
		if (st == 32'h2)
		begin
			chk(dev.regs[1], s);
			chk(dev.regs[0], e);
			chk(dev.regs[2], {14'h0, `BSC_PAT_STEP});
		end
	endtask

	task automatic t_pat();
		wr(`BSC_IX_POFF, 32'h0300);
		pat(0, 32'h100, 32'h160, 32'h162, 32'h2);
		pat(0, 32'h118, 32'h178, 32'h17A, 32'h2);
		pat(1, 32'h110, 32'h170, 32'h174, 32'h2);
		pat(2, 32'h110, 32'h170, 32'h177, 32'h2);
		pat(3, 32'h108, 32'h168, 32'h16E, 32'h2);
		pat(1, 32'h118, 32'h0, 32'h0, 32'h200);
		pat(2, 32'h108, 32'h0, 32'h0, 32'h200);
	endtask

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_xy();
		t_ops();
		t_lin();
		t_fast();
		t_pat();
		tally_and_finish();
	end

	// Whole run needs well under ten thousand cycles
	initial
	begin
		repeat (40000) @(posedge aclk);
		errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
